/* File: hw/bmp_ctrl.sv */
// Burst-mode PWM and fault sequencer of a quasi-resonant flyback controller
`timescale 1ns/1ps
`default_nettype none
module bmp_ctrl #(
  parameter int OPEN_LOOP_CYC = bmp_pkg::OPEN_LOOP_BLANK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fb_above_restart,   // Feedback above burst_restart_level
  input wire logic fb_below_pause,     // Feedback at or below burst_pause_level
  input wire logic fb_above_exit,      // Feedback above burst_exit_level
  input wire logic fb_below_entry,     // Feedback below burst entry level
  input wire logic fb_open_loop,       // Feedback pulled high
  input wire logic cs_above_burst,     // Sense above burst_current_limit
  input wire logic cs_above_peak,      // Normal-mode current turn-off
  input wire logic cs_above_short,     // Sense above short_winding_level
  input wire logic zc_above_ovp,       // zero_crossing_input above output_overvoltage_level
  input wire logic supply_ok,          // Supply above supply_turnon_level since last drop
  input wire logic supply_low,         // Supply below supply_turnoff_level
  input wire logic supply_ovp,         // Supply over-voltage
  input wire logic supply_release,     // Supply below latch release level
  input wire logic over_temp,          // Junction over-temperature
  input wire logic normal_turn_on,     // Valley logic turn-on request
  input wire logic valley_dec,         // Valley counter down request
  input wire logic valley_inc,         // Valley counter up request
  output logic gate_drive,
  output logic startup_on,
  output logic bias_on,
  output logic burst_active,
  output logic latched_off,
  output logic [2:0] valley_count
);

  localparam int NSYNC = bmp_pkg::SYNC_WIDTH;
  localparam logic [8:0] PERIOD_LAST = 9'(bmp_pkg::BURST_PERIOD_CYC - 1);
  localparam logic [8:0] MAX_DUTY = 9'(bmp_pkg::BURST_MAX_ON_CYC);
  // Turn-off is decided one count early so the pulse never exceeds half a period
  localparam logic [8:0] DUTY_LAST = 9'(bmp_pkg::BURST_MAX_ON_CYC - 1);
  localparam logic [9:0] MAX_ON = 10'(bmp_pkg::MAX_ON_TIME_CYC);
  localparam logic [4:0] OVP_BLANK = 5'(bmp_pkg::OVP_BLANK_CYC);
  localparam logic [9:0] ENTRY_BLANK = 10'(bmp_pkg::BURST_ENTRY_BLANK_CYC);
  localparam logic [19:0] OPEN_LOOP = 20'(OPEN_LOOP_CYC);

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;

  assign raw = {fb_above_restart, fb_below_pause, fb_above_exit, fb_below_entry,
                fb_open_loop, cs_above_burst, cs_above_peak, cs_above_short,
                zc_above_ovp, over_temp, supply_release};

  bmp_sync #(.WIDTH(NSYNC)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(raw),
    .sync_out(syn)
  );

  // Supply flags pass their own pair of stages
  logic [2:0] sup_syn;
  bmp_sync #(.WIDTH(3)) u_sup_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({supply_ok, supply_low, supply_ovp}),
    .sync_out(sup_syn)
  );

  logic s_restart, s_pause, s_exit, s_entry, s_open, s_csb, s_csp, s_css, s_ovp;
  logic s_ot, s_rel, s_ok, s_low, s_vovp;
  assign {s_restart, s_pause, s_exit, s_entry, s_open, s_csb, s_csp, s_css, s_ovp,
          s_ot, s_rel} = syn;
  assign {s_ok, s_low, s_vovp} = sup_syn;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    bmp_pkg::bmp_mode_e mode;
    logic gate;
    logic startup;
    logic [8:0] timer;
    logic [9:0] on_cnt;
    logic [19:0] open_cnt;
    logic [4:0] ovp_cnt;
    logic [9:0] entry_cnt;
    logic [2:0] valley;
    logic bias;
    logic burst;
    logic latch;
  } bmp_ctrl_s;

  bmp_ctrl_s state;
  bmp_ctrl_s next_state;

  logic active;
  assign active = (state.mode == bmp_pkg::BMP_NORMAL) || (state.mode == bmp_pkg::BMP_BURST);

  // ------------------------------------------------------------
  // Mode sequencer and gate control
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.timer = (state.timer == PERIOD_LAST) ? 9'h000 : state.timer + 9'h001;
    next_state.on_cnt = state.gate ? state.on_cnt + 10'h001 : 10'h000;
    // Long-running blanking counts saturate instead of wrapping
    next_state.open_cnt = (s_open && active) ?
                          ((state.open_cnt == OPEN_LOOP) ? state.open_cnt
                                                         : state.open_cnt + 20'h00001)
                          : 20'h00000;
    next_state.ovp_cnt = (s_ovp && !state.gate && active) ?
                         ((state.ovp_cnt == OVP_BLANK) ? state.ovp_cnt
                                                       : state.ovp_cnt + 5'h01)
                         : 5'h00;
    next_state.entry_cnt = (s_entry && state.valley == bmp_pkg::VALLEY_BURST_ENTRY &&
                            state.mode == bmp_pkg::BMP_NORMAL) ?
                           ((state.entry_cnt == ENTRY_BLANK) ? state.entry_cnt
                                                             : state.entry_cnt + 10'h001)
                           : 10'h000;
    // Valley counter in normal operation
    if (state.mode == bmp_pkg::BMP_NORMAL) begin
      if (valley_inc && state.valley != 3'h7) begin
        next_state.valley = state.valley + 3'h1;
      end else if (valley_dec && state.valley != 3'h0) begin
        next_state.valley = state.valley - 3'h1;
      end
    end
    case (state.mode)
      bmp_pkg::BMP_OFF: begin
        next_state.gate = 1'b0;
        if (s_low) begin
          next_state.startup = 1'b1;
        end
        if (s_ok && !s_vovp) begin
          next_state.startup = 1'b0;
          next_state.mode = bmp_pkg::BMP_NORMAL;
          next_state.valley = bmp_pkg::VALLEY_AT_START;
        end
      end
      bmp_pkg::BMP_NORMAL: begin
        if (!state.gate && normal_turn_on) begin
          next_state.gate = 1'b1;
        end else if (state.gate && s_csp) begin
          next_state.gate = 1'b0;
        end
        if (state.entry_cnt == ENTRY_BLANK) begin
          next_state.mode = bmp_pkg::BMP_BURST;
          next_state.gate = 1'b0;
          next_state.timer = 9'h000;
        end
      end
      bmp_pkg::BMP_BURST: begin
        if (state.timer == PERIOD_LAST) begin
          next_state.gate = 1'b1;
        end
        if (state.gate && (s_csb || state.timer >= DUTY_LAST)) begin
          next_state.gate = 1'b0;
        end
        if (s_pause) begin
          next_state.mode = bmp_pkg::BMP_PAUSE;
          next_state.gate = 1'b0;
        end
      end
      bmp_pkg::BMP_PAUSE: begin
        next_state.gate = 1'b0;
        if (s_restart) begin
          next_state.mode = bmp_pkg::BMP_BURST;
          next_state.timer = PERIOD_LAST;
        end
      end
      bmp_pkg::BMP_RESTART: begin
        next_state.gate = 1'b0;
        next_state.mode = bmp_pkg::BMP_OFF;
      end
      bmp_pkg::BMP_LATCHED: begin
        next_state.gate = 1'b0;
        if (s_low) begin
          next_state.startup = 1'b1;
        end else if (s_ok) begin
          next_state.startup = 1'b0;
        end
        if (s_rel) begin
          next_state.mode = bmp_pkg::BMP_OFF;
          next_state.startup = 1'b1;
        end
      end
      default: begin
        next_state.mode = bmp_pkg::BMP_OFF;
        next_state.gate = 1'b0;
      end
    endcase
    if ((state.mode == bmp_pkg::BMP_BURST || state.mode == bmp_pkg::BMP_PAUSE) && s_exit) begin
      next_state.mode = bmp_pkg::BMP_NORMAL;
      next_state.valley = bmp_pkg::VALLEY_AFTER_BURST;
      next_state.gate = 1'b0;
    end
    if (state.gate && state.on_cnt >= MAX_ON) begin
      next_state.gate = 1'b0;
    end
    if (active) begin
      if (state.open_cnt == OPEN_LOOP || s_ot) begin
        next_state.mode = bmp_pkg::BMP_RESTART;
        next_state.gate = 1'b0;
      end
      if (state.ovp_cnt == OVP_BLANK || (state.gate && s_css)) begin
        next_state.mode = bmp_pkg::BMP_LATCHED;
        next_state.gate = 1'b0;
      end
    end
    // supply fault resets and holds off
    // A burst pause must not hide a supply fault, so it is watched there too
    if ((active || state.mode == bmp_pkg::BMP_PAUSE) && (!s_ok || s_vovp)) begin
      next_state.mode = bmp_pkg::BMP_OFF;
      next_state.gate = 1'b0;
    end
    // Mode flags are registered so every pin leaves a flip-flop
    next_state.bias = (next_state.mode == bmp_pkg::BMP_NORMAL) ||
                      (next_state.mode == bmp_pkg::BMP_BURST);
    next_state.burst = (next_state.mode == bmp_pkg::BMP_BURST) ||
                       (next_state.mode == bmp_pkg::BMP_PAUSE);
    next_state.latch = (next_state.mode == bmp_pkg::BMP_LATCHED);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign gate_drive = state.gate;
  assign startup_on = state.startup;
  assign bias_on = state.bias;
  assign burst_active = state.burst;
  assign latched_off = state.latch;
  assign valley_count = state.valley;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_burst_duty_cap: assert property (@(posedge sys_clk) disable iff (rst)
    (state.mode == bmp_pkg::BMP_BURST && state.gate) |-> state.timer < MAX_DUTY)
    else $error("burst on-time beyond half period");
  a_burst_turn_on: assert property (@(posedge sys_clk) disable iff (rst)
    (state.mode == bmp_pkg::BMP_BURST && $rose(gate_drive)) |-> $past(state.timer) == PERIOD_LAST)
    else $error("burst turn-on not timer driven");
  a_burst_csb_off: assert property (@(posedge sys_clk) disable iff (rst)
    (state.mode == bmp_pkg::BMP_BURST && state.gate && s_csb) |=> !gate_drive)
    else $error("burst current limit ignored");
  a_pause_no_gate: assert property (@(posedge sys_clk) disable iff (rst)
    (state.mode == bmp_pkg::BMP_PAUSE) |-> !gate_drive)
    else $error("gate active while paused");
  a_pause_restart: assert property (@(posedge sys_clk) disable iff (rst)
    (state.mode == bmp_pkg::BMP_PAUSE && s_restart && !s_exit && s_ok && !s_vovp &&
     !s_ot && state.open_cnt != OPEN_LOOP) |=> state.mode == bmp_pkg::BMP_BURST)
    else $error("pause did not restart");
  a_exit_valley_one: assert property (@(posedge sys_clk) disable iff (rst)
    (burst_active && s_exit && s_ok && !s_vovp) |=> valley_count == 3'h1)
    else $error("valley not one after burst exit");
  a_max_on_time: assert property (@(posedge sys_clk) disable iff (rst)
    gate_drive |-> state.on_cnt <= MAX_ON)
    else $error("gate beyond maximum on-time");
  a_short_latch: assert property (@(posedge sys_clk) disable iff (rst)
    (active && gate_drive && s_css && s_ok && !s_vovp) |=> latched_off)
    else $error("short winding not latched");
  a_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (latched_off && !s_rel) |=> latched_off)
    else $error("latch released early");

endmodule
`default_nettype wire

/* File: hw/bmp_pkg.sv */
// Constants and types shared by the burst-mode and protection controller
package bmp_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int BURST_TIMER_HZ = 52000;                       // Burst turn-on timer rate
  localparam int BURST_PERIOD_CYC = CLK_HZ / BURST_TIMER_HZ;   // 480 cycles, rounded down
  localparam int BURST_MAX_DUTY_PCT = 50;
  localparam int BURST_MAX_ON_CYC = BURST_PERIOD_CYC * BURST_MAX_DUTY_PCT / 100;
  localparam int OPEN_LOOP_BLANK_MS = 24;
  localparam int OPEN_LOOP_BLANK_CYC = CLK_HZ / 1000 * OPEN_LOOP_BLANK_MS;
  localparam int MAX_ON_TIME_US = 30;                          // Typical maximum on-time
  localparam int MAX_ON_TIME_CYC = CLK_HZ / 1000000 * MAX_ON_TIME_US;
  localparam int OVP_BLANK_US = 1;                             // Output OVP blanking
  localparam int OVP_BLANK_CYC = CLK_HZ / 1000000 * OVP_BLANK_US;
  localparam int BURST_ENTRY_BLANK_US = 20;                    // Burst entry blanking
  localparam int BURST_ENTRY_BLANK_CYC = CLK_HZ / 1000000 * BURST_ENTRY_BLANK_US;

  // ------------------------------------------------------------
  // Valley counter
  // ------------------------------------------------------------
  localparam logic [2:0] VALLEY_BURST_ENTRY = 3'h7;
  localparam logic [2:0] VALLEY_AFTER_BURST = 3'h1;
  localparam logic [2:0] VALLEY_AT_START = 3'h1;                // Count of one on a fresh start; valley_dec can still step it down to zero
  localparam int SYNC_WIDTH = 11;

  // ------------------------------------------------------------
  // Operating modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    BMP_OFF     = 3'b000,
    BMP_NORMAL  = 3'b001,
    BMP_BURST   = 3'b010,
    BMP_PAUSE   = 3'b011,
    BMP_RESTART = 3'b100,
    BMP_LATCHED = 3'b101
  } bmp_mode_e;

endpackage

/* File: hw/bmp_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module bmp_sync #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } bmp_sync_s;

  bmp_sync_s state;
  bmp_sync_s next_state;

  // First stage is read only by the second stage
  always_comb begin
    next_state = state;
    next_state.first = async_in;
    next_state.second = state.first;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.second;

endmodule
`default_nettype wire

/* File: bench/bmp_far_model.sv */
// Far-side model: power switch current ramp and sense comparators
`timescale 1ns/1ps
`default_nettype none
module bmp_far_model (
  input wire logic sys_clk,
  input wire logic gate_drive,
  input wire logic [9:0] ramp_cyc,
  input wire logic short_en,
  output logic cs_above_burst,
  output logic cs_above_short
);
  // ------------------------------------------------------------
  // Current ramp
  // ------------------------------------------------------------
  int on_cnt = 0;

  // Sense current grows while the switch conducts and collapses when it opens
  always @(posedge sys_clk) begin
    on_cnt <= gate_drive ? on_cnt + 1 : 0;
  end

  // A large ramp_cyc gives a slow ramp, so the duty limit wins instead
  assign cs_above_burst = gate_drive && (on_cnt >= int'(ramp_cyc));
  // Shorted winding only shows while the switch is on
  assign cs_above_short = short_en && gate_drive;
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the burst-mode and protection controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int OL_CYC = 50;  // Short open-loop blanking keeps the run brief
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic fb_above_restart, fb_below_pause, fb_above_exit, fb_below_entry, fb_open_loop;
  logic cs_above_peak, zc_above_ovp, supply_ok, supply_low, supply_ovp, supply_release;
  logic over_temp, normal_turn_on, valley_dec, valley_inc, short_en;
  logic [9:0] ramp_cyc;
  logic cs_above_burst, cs_above_short;
  logic gate_drive, startup_on, bias_on, burst_active, latched_off;
  logic [2:0] valley_count;
  int error_cnt = 0;
  int checked = 0;
  int on, per, hits, r;

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  bmp_ctrl #(.OPEN_LOOP_CYC(OL_CYC)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .fb_above_restart(fb_above_restart), .fb_below_pause(fb_below_pause),
    .fb_above_exit(fb_above_exit), .fb_below_entry(fb_below_entry),
    .fb_open_loop(fb_open_loop), .cs_above_burst(cs_above_burst),
    .cs_above_peak(cs_above_peak), .cs_above_short(cs_above_short),
    .zc_above_ovp(zc_above_ovp), .supply_ok(supply_ok), .supply_low(supply_low),
    .supply_ovp(supply_ovp), .supply_release(supply_release), .over_temp(over_temp),
    .normal_turn_on(normal_turn_on), .valley_dec(valley_dec), .valley_inc(valley_inc),
    .gate_drive(gate_drive), .startup_on(startup_on), .bias_on(bias_on),
    .burst_active(burst_active), .latched_off(latched_off), .valley_count(valley_count));

  bmp_far_model far_u (.sys_clk(sys_clk), .gate_drive(gate_drive), .ramp_cyc(ramp_cyc),
    .short_en(short_en), .cs_above_burst(cs_above_burst), .cs_above_short(cs_above_short));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Inputs always move 1 ns after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: sig = gate_drive;
      1: sig = startup_on;
      2: sig = bias_on;
      3: sig = burst_active;
      default: sig = latched_off;
    endcase
  endfunction

  // Bounded wait; running out of time ends the run as a failure
  task automatic wait_sig(input int k, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && sig(k) !== v; i++) step(1);
    check(sig(k), v);
    if (sig(k) !== v) stop_test();
  endtask

  // Counts cycles where an output leaves the value it must hold
  task automatic hold(input int k, input logic v, input int n);
    hits = 0;
    repeat (n) begin
      step(1);
      hits += (sig(k) !== v);
    end
  endtask

  // On-time and rise-to-rise period of one gate pulse
  task automatic measure();
    wait_sig(0, 1'b1, 1200);
    on = 0;
    while (gate_drive === 1'b1 && on < 2000) begin
      step(1);
      on++;
    end
    per = on;
    while (gate_drive !== 1'b1 && per < 2000) begin
      step(1);
      per++;
    end
  endtask

  task automatic stop_test();
    $display("errors %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {fb_above_restart, fb_below_pause, fb_above_exit, fb_below_entry, fb_open_loop} = '0;
    {cs_above_peak, zc_above_ovp, supply_ok, supply_low, supply_ovp, supply_release} = '0;
    {over_temp, normal_turn_on, valley_dec, valley_inc, short_en} = '0;
    ramp_cyc = 10'h3FF;
    void'($urandom(32));
    step(16);
    rst = 1'b0;
    check({gate_drive, startup_on, bias_on, burst_active, latched_off, valley_count}, 0);
    supply_ok = 1'b1;
    wait_sig(2, 1'b1, 10);
    // Valley counter saturates at seven and steps down
    repeat (8) begin
      valley_inc = 1'b1;
      step(1);
      valley_inc = 1'b0;
      step(1);
    end
    check(valley_count, 3'h7);
    valley_dec = 1'b1;
    step(1);
    valley_dec = 1'b0;
    step(2);
    check(valley_count, 3'h6);
    valley_inc = 1'b1;
    step(1);
    valley_inc = 1'b0;
    step(2);
    // Unbroken on-request: only the on-time limit ends the pulse
    normal_turn_on = 1'b1;
    measure();
    normal_turn_on = 1'b0;
    check(on >= bmp_pkg::MAX_ON_TIME_CYC && on <= bmp_pkg::MAX_ON_TIME_CYC + 3, 1);
    wait_sig(0, 1'b0, 800);
    // Full peak current again: the normal comparator ends a pulse
    normal_turn_on = 1'b1;
    step(1);
    normal_turn_on = 1'b0;
    check(gate_drive, 1'b1);
    cs_above_peak = 1'b1;
    wait_sig(0, 1'b0, 8);
    cs_above_peak = 1'b0;
    // Burst entry must wait out the blanking time
    fb_below_entry = 1'b1;
    hold(3, 1'b0, 400);
    check(hits, 0);
    wait_sig(3, 1'b1, 200);
    fb_below_entry = 1'b0;
    // Slow ramp: the duty limit ends each pulse
    measure();
    check(per, bmp_pkg::BURST_PERIOD_CYC);
    check(on >= bmp_pkg::BURST_MAX_ON_CYC && on <= bmp_pkg::BURST_MAX_ON_CYC + 3, 1);
    // Fast random ramp: the current limit comes first
    r = 40 + ($urandom % 100);
    ramp_cyc = r[9:0];
    measure();
    measure();
    check(on >= r && on <= r + 4, 1);
    check(per, bmp_pkg::BURST_PERIOD_CYC);
    ramp_cyc = 10'h3FF;
    // Pause stops switching until the restart level
    fb_below_pause = 1'b1;
    wait_sig(2, 1'b0, 10);
    hold(0, 1'b0, 1000);
    check(hits, 0);
    check(burst_active, 1'b1);
    fb_below_pause = 1'b0;
    fb_above_restart = 1'b1;
    wait_sig(0, 1'b1, 8);
    // Leaving burst reloads the valley counter
    fb_above_exit = 1'b1;
    wait_sig(3, 1'b0, 8);
    check(valley_count, 3'h1);
    check(bias_on, 1'b1);
    fb_above_exit = 1'b0;
    fb_above_restart = 1'b0;
    // Open loop must persist for the whole blanking time
    fb_open_loop = 1'b1;
    hold(2, 1'b1, 30);
    check(hits, 0);
    wait_sig(2, 1'b0, 40);
    fb_open_loop = 1'b0;
    wait_sig(2, 1'b1, 20);
    over_temp = 1'b1;
    wait_sig(2, 1'b0, 8);
    over_temp = 1'b0;
    wait_sig(2, 1'b1, 20);
    // Output overvoltage during off-time latches after blanking
    zc_above_ovp = 1'b1;
    hold(4, 1'b0, 15);
    check(hits, 0);
    wait_sig(4, 1'b1, 40);
    zc_above_ovp = 1'b0;
    over_temp = 1'b1;
    step(10);
    over_temp = 1'b0;
    check({latched_off, gate_drive}, 2'h2);
    supply_release = 1'b1;
    wait_sig(4, 1'b0, 8);
    supply_release = 1'b0;
    wait_sig(2, 1'b1, 20);
    // Short winding while on, then startup cell cycling
    short_en = 1'b1;
    normal_turn_on = 1'b1;
    wait_sig(4, 1'b1, 20);
    check(gate_drive, 1'b0);
    short_en = 1'b0;
    normal_turn_on = 1'b0;
    repeat (2) begin
      supply_low = 1'b1;
      supply_ok = 1'b0;
      wait_sig(1, 1'b1, 8);
      supply_low = 1'b0;
      supply_ok = 1'b1;
      wait_sig(1, 1'b0, 8);
    end
    check(latched_off, 1'b1);
    supply_release = 1'b1;
    wait_sig(4, 1'b0, 8);
    supply_release = 1'b0;
    wait_sig(2, 1'b1, 20);
    // Supply overvoltage resets, then a fresh start
    supply_ovp = 1'b1;
    wait_sig(2, 1'b0, 8);
    check(gate_drive, 1'b0);
    supply_low = 1'b1;
    supply_ok = 1'b0;
    supply_ovp = 1'b0;
    wait_sig(1, 1'b1, 8);
    supply_low = 1'b0;
    supply_ok = 1'b1;
    wait_sig(2, 1'b1, 10);
    check(startup_on, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
